// ==== logic/asr_map.svh ====
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_WORD_W         16
`define ASR_MCLK_NS        100
`define ASR_START_DELAY_NS 270
`define ASR_START_DELAY_CYC \
  ((`ASR_START_DELAY_NS + `ASR_MCLK_NS - 1) / `ASR_MCLK_NS)
`define ASR_SYNC_GUARD     2
`define ASR_LAST_BIT       4'hf
`endif

// ==== logic/asr_pkg.sv ====
package asr_pkg;
  typedef enum logic [2:0] {
    ASR_I_IDLE, ASR_I_DELAY, ASR_I_SET, ASR_I_HIGH, ASR_I_HOLD
  } asr_int_state_t;
  typedef enum logic [1:0] {
    ASR_L_IDLE, ASR_L_SYNC, ASR_L_SHIFT, ASR_L_TAIL
  } asr_link_state_t;
  typedef struct packed {
    logic [15:0] word;
    logic        tag;
  } asr_hold_t;
endpackage : asr_pkg

// ==== logic/asr_readout.sv ====
`include "asr_map.svh"
module asr_readout
  import asr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        chip_select_n,
  input  wire logic        read_convert,
  input  wire logic        ext_clock_select,
  input  wire logic        output_format_select,
  input  wire logic        chain_in,
  input  wire logic [15:0] result_word,
  input  wire logic        result_load,
  input  wire logic        serial_bit_clock_in,
  output logic             serial_bit_clock_o,
  output logic             serial_bit_clock_oe,
  output logic             serial_data,
  output logic             word_start_pulse,
  output logic             convert_start,
  output logic             read_active
);
  // ***************************************************
  // pin synchronisers and edge detection (mclk)
  // ***************************************************
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic       cs_prev_r;
  logic       rc_prev_r;
  logic       cs_q;
  logic       rc_q;
  logic       ext_q;
  logic       fmt_q;
  logic       tag_q;
  logic       sel_n;
  logic       rd_start;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_r <= 5'h01;
      pin_sync_r <= 5'h01;
      cs_prev_r  <= 1'b1;
      rc_prev_r  <= 1'b0;
    end else begin
      pin_meta_r <= {chain_in, output_format_select, ext_clock_select,
                     read_convert, chip_select_n};
      pin_sync_r <= pin_meta_r;
      cs_prev_r  <= cs_q;
      rc_prev_r  <= rc_q;
    end
  end

  assign cs_q  = pin_sync_r[0];
  assign rc_q  = pin_sync_r[1];
  assign ext_q = pin_sync_r[2];
  assign fmt_q = pin_sync_r[3];
  assign tag_q = pin_sync_r[4];
  assign sel_n = cs_q | rc_q;
  // the second of the two to go low starts the conversion
  assign convert_start = (cs_prev_r | rc_prev_r) & ~sel_n;
  assign rd_start = ext_q & ((~rc_prev_r & rc_q & ~cs_q)
                    | (cs_prev_r & ~cs_q & rc_q));

  // ***************************************************
  // result capture and external read request
  // ***************************************************
  logic [15:0] last_result_r;
  asr_hold_t   hold_r;
  logic        req_tgl_r;
  logic        read_level_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      last_result_r <= 16'h0000;
    end else if (result_load) begin
      // core delivers straight binary; msb flip gives two's complement
      last_result_r <= {result_word[15] ^ ~fmt_q, result_word[14:0]};
    end
  end

  // hold_r stays still from the toggle onward, so the link side may
  // take it as a whole word once the toggle has crossed
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_r    <= '0;
      req_tgl_r <= 1'b0;
    end else if (rd_start) begin
      hold_r    <= '{word: last_result_r, tag: tag_q};
      req_tgl_r <= ~req_tgl_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      read_level_r <= 1'b0;
    end else if (rd_start) begin
      read_level_r <= 1'b1;
    end else if (cs_q | ~rc_q | ~ext_q) begin
      read_level_r <= 1'b0;
    end
  end
  assign read_active = read_level_r;

  // ***************************************************
  // internal bit clock engine (mclk)
  // ***************************************************
  asr_int_state_t istate_r;
  logic [1:0]     dly_cnt_r;
  logic [3:0]     ibit_r;
  logic [15:0]    ishift_r;
  logic           itag_r;
  logic           iclk_r;
  logic           idata_r;
  logic           itail_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      istate_r  <= ASR_I_IDLE;
      dly_cnt_r <= 2'h0;
      ibit_r    <= 4'h0;
      ishift_r  <= 16'h0000;
      itag_r    <= 1'b0;
      iclk_r    <= 1'b0;
      idata_r   <= 1'b0;
      itail_r   <= 1'b0;
    end else begin
      case (istate_r)
        ASR_I_IDLE: begin
          iclk_r <= 1'b0;
          if (convert_start && !ext_q) begin
            ishift_r  <= last_result_r;
            itag_r    <= tag_q;
            dly_cnt_r <= 2'(`ASR_START_DELAY_CYC - 1);
            ibit_r    <= 4'h0;
            istate_r  <= ASR_I_DELAY;
          end
        end
        ASR_I_DELAY: begin
          if (dly_cnt_r == 2'h0) begin
            istate_r <= ASR_I_SET;
          end else begin
            dly_cnt_r <= dly_cnt_r - 2'h1;
          end
        end
        ASR_I_SET: begin
          // data moves only while the clock sits low
          idata_r  <= ishift_r[15];
          ishift_r <= {ishift_r[14:0], 1'b0};
          istate_r <= ASR_I_HIGH;
        end
        ASR_I_HIGH: begin
          iclk_r   <= 1'b1;
          istate_r <= ASR_I_HOLD;
        end
        ASR_I_HOLD: begin
          iclk_r <= 1'b0;
          if (ibit_r == `ASR_LAST_BIT) begin
            istate_r <= ASR_I_IDLE;
          end else begin
            ibit_r   <= ibit_r + 4'h1;
            istate_r <= ASR_I_SET;
          end
        end
        default: istate_r <= ASR_I_IDLE;
      endcase
      // tail waits one cycle so the last bit still stands at the fall
      itail_r <= (istate_r == ASR_I_HOLD && ibit_r == `ASR_LAST_BIT);
      if (itail_r) begin
        idata_r <= itag_r;
      end
    end
  end

  // ***************************************************
  // link domain reset
  // ***************************************************
  logic lrst_req_r;
  logic lrst_a_r;
  logic link_rst;

  always_ff @(posedge mclk) begin
    lrst_req_r <= reset;
  end

  // asserts at once, releases on link edges; the link clock may stand
  // still, so link flops keep their reset values until it runs
  always_ff @(posedge serial_bit_clock_in or posedge lrst_req_r) begin
    if (lrst_req_r) begin
      lrst_a_r <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      lrst_a_r <= 1'b0;
      link_rst <= lrst_a_r;
    end
  end

  // ***************************************************
  // external clock shifter (link domain)
  // ***************************************************
  logic            req_m_r;
  logic            req_s_r;
  logic            req_seen_r;
  logic            rd_m_r;
  logic            rd_s_r;
  logic            ext_m_r;
  logic            ext_s_r;
  logic [1:0]      idle_cnt_r;
  asr_link_state_t lstate_r;
  logic [15:0]     lword_r;
  logic [3:0]      lidx_r;
  logic            ltag_r;
  logic            ldata_r;
  logic            lsync_r;
  logic            lstart;

  always_ff @(posedge serial_bit_clock_in or posedge link_rst) begin
    if (link_rst) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      rd_m_r  <= 1'b0;
      rd_s_r  <= 1'b0;
      ext_m_r <= 1'b0;
      ext_s_r <= 1'b0;
    end else begin
      req_m_r <= req_tgl_r;
      req_s_r <= req_m_r;
      rd_m_r  <= read_level_r;
      rd_s_r  <= rd_m_r;
      ext_m_r <= ext_q;
      ext_s_r <= ext_m_r;
    end
  end
  assign lstart = req_s_r ^ req_seen_r;

  // the two edges that carry the request across also count as idle
  // edges, hence the guard before a word-start pulse is granted;
  // the device's own internal pulses count only while ext_s_r lags: the first two after leaving external mode
  always_ff @(posedge serial_bit_clock_in or posedge link_rst) begin
    if (link_rst) begin
      idle_cnt_r <= 2'h0;
    end else if (lstart) begin
      idle_cnt_r <= 2'h0;
    end else if (lstate_r == ASR_L_IDLE && ext_s_r
                 && idle_cnt_r != 2'h3) begin
      idle_cnt_r <= idle_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge serial_bit_clock_in or posedge link_rst) begin
    if (link_rst) begin
      req_seen_r <= 1'b0;
      lstate_r   <= ASR_L_IDLE;
      lword_r    <= 16'h0000;
      lidx_r     <= 4'h0;
      ltag_r     <= 1'b0;
      ldata_r    <= 1'b0;
      lsync_r    <= 1'b0;
    end else if (lstart) begin
      req_seen_r <= req_s_r;
      lword_r    <= hold_r.word;
      ltag_r     <= hold_r.tag;
      lidx_r     <= `ASR_LAST_BIT;
      if (idle_cnt_r > 2'(`ASR_SYNC_GUARD)) begin
        lsync_r  <= 1'b1;
        lstate_r <= ASR_L_SYNC;
      end else begin
        ldata_r  <= hold_r.word[15];
        lstate_r <= ASR_L_SHIFT;
      end
    end else begin
      case (lstate_r)
        ASR_L_SYNC: begin
          lsync_r  <= 1'b0;
          ldata_r  <= lword_r[15];
          lstate_r <= ASR_L_SHIFT;
        end
        ASR_L_SHIFT: begin
          // new bit on each rising edge: valid at the falling edge and
          // at the next rising edge
          if (lidx_r == 4'h0) begin
            ldata_r  <= ltag_r;
            lstate_r <= ASR_L_TAIL;
          end else begin
            ldata_r <= lword_r[lidx_r - 4'h1];
            lidx_r  <= lidx_r - 4'h1;
          end
        end
        ASR_L_TAIL: begin
          if (!rd_s_r) begin
            lstate_r <= ASR_L_IDLE;
          end
        end
        default: lstate_r <= ASR_L_IDLE;
      endcase
    end
  end

  // ***************************************************
  // pins
  // ***************************************************
  assign serial_bit_clock_oe = ~ext_q;
  assign serial_bit_clock_o  = iclk_r;
  assign serial_data         = ext_q ? ldata_r : idata_r;
  assign word_start_pulse    = ext_q & lsync_r;

  // ***************************************************
  // checks (mclk)
  // ***************************************************
  logic [4:0] pulse_cnt_r;
  always_ff @(posedge mclk) begin
    if (reset || istate_r == ASR_I_IDLE) begin
      pulse_cnt_r <= 5'h00;
    end else if (istate_r == ASR_I_HIGH) begin
      pulse_cnt_r <= pulse_cnt_r + 5'h01;
    end
  end

  sequence seq_int_start;
    convert_start && !ext_q && istate_r == ASR_I_IDLE;
  endsequence
  sequence seq_int_delay;
    (istate_r == ASR_I_DELAY)[*3] ##1 istate_r == ASR_I_SET;
  endsequence

  chk_int_delay: assert property (@(posedge mclk) disable iff (reset)
    seq_int_start |=> seq_int_delay)
    else $error("internal start delay wrong");
  chk_pulse_count: assert property (@(posedge mclk) disable iff (reset)
    istate_r == ASR_I_HOLD && ibit_r == 4'hf |-> pulse_cnt_r == 5'h10)
    else $error("internal frame not 16 pulses");
  chk_clk_idle: assert property (@(posedge mclk) disable iff (reset)
    istate_r == ASR_I_IDLE |=> !serial_bit_clock_o)
    else $error("internal bit clock not low when idle");
  chk_bit_hold: assert property (@(posedge mclk) disable iff (reset)
    $rose(iclk_r) |-> $stable(idata_r) ##1 $stable(idata_r))
    else $error("data moved around bit clock pulse");
  chk_tail_tag: assert property (@(posedge mclk) disable iff (reset)
    istate_r == ASR_I_HOLD && ibit_r == 4'hf
      |=> ##1 idata_r == $past(itag_r))
    else $error("tail not chain level");
  chk_pin_dir: assert property (@(posedge mclk) disable iff (reset)
    $rose(ext_q) |=> !serial_bit_clock_oe [*2])
    else $error("bit clock driven in external mode");
  chk_conv_start: assert property (@(posedge mclk) disable iff (reset)
    $past(sel_n) && !sel_n |-> convert_start)
    else $error("conversion start missed");
  chk_read_req: assert property (@(posedge mclk) disable iff (reset)
    rd_start |=> req_tgl_r != $past(req_tgl_r) && read_level_r)
    else $error("read request not raised");
  chk_fmt_msb: assert property (@(posedge mclk) disable iff (reset)
    result_load |=> last_result_r[15] == ($past(result_word[15])
      ^ ~$past(fmt_q)))
    else $error("result format wrong");

  // ***************************************************
  // checks (link clock)
  // ***************************************************
  chk_sync_then_msb: assert property (@(posedge serial_bit_clock_in)
    disable iff (link_rst)
    lstate_r == ASR_L_SYNC |-> lsync_r ##1 (!lsync_r
      && ldata_r == lword_r[15]))
    else $error("word-start pulse not followed by msb");
  chk_nosync_msb: assert property (@(posedge serial_bit_clock_in)
    disable iff (link_rst)
    lstart && idle_cnt_r <= 2'h2 |=> !lsync_r && ldata_r == lword_r[15])
    else $error("msb not first without word-start");
endmodule : asr_readout

// ==== tb/asr_host_model.sv ====
// ****************************************
// host serial port reading results
// ****************************************
module asr_host_model (
  output logic      bclk,
  input  wire logic sdata,
  input  wire logic wsp
);
  timeunit 1ns;
  timeprecision 1ns;

  // 48 ns period, well under the link ceiling
  localparam int HALF = 24;

  // clock stands low outside frames
  initial bclk = 1'b0;

  task automatic clocks(input int n);
    repeat (n) begin
      #HALF bclk = 1'b1;
      #HALF bclk = 1'b0;
    end
  endtask : clocks

  // two crossing edges, optional word-start edge, 16 bits, chain bit
  task automatic read_word(
    input  logic        pulse,
    output logic [15:0] w,
    output logic        tag,
    output logic        ws,
    output int          unstable
  );
    logic s;
    int   lead;
    w = 16'h0000;
    tag = 1'b0;
    ws = 1'b0;
    unstable = 0;
    lead = pulse ? 3 : 2;
    for (int k = 1; k <= lead + 17; k++) begin
      bclk = 1'b1;
      #HALF bclk = 1'b0;
      s = sdata;
      if (k == 3) ws = wsp;
      if (k > lead && k <= lead + 16) w = {w[14:0], s};
      if (k == lead + 17) tag = s;
      #(HALF - 1);
      // the bit must still stand just before the next rising edge
      if (k >= 3 && sdata !== s) unstable++;
      #1;
    end
  endtask : read_word
endmodule : asr_host_model

// ==== tb/asr_readout_test.sv ====
module asr_readout_test;
  timeunit 1ns;
  timeprecision 1ns;
  import asr_pkg::*;

  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        chip_select_n = 1'b1;
  logic        read_convert = 1'b1;
  logic        ext_clock_select = 1'b0;
  logic        output_format_select = 1'b1;
  logic        chain_in = 1'b0;
  logic [15:0] result_word = 16'h0000;
  logic        result_load = 1'b0;
  logic        host_clk;
  logic        sbc_o;
  logic        sbc_oe;
  logic        serial_data;
  logic        word_start_pulse;
  logic        convert_start;
  logic        read_active;
  wire         bit_clock_pin = sbc_oe ? sbc_o : host_clk;
  int          fails = 0;
  int          n_checks = 0;
  int          n_conv = 0;
  logic [15:0] w;
  logic        tag;
  logic        ws;
  int          unstable;

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    if (convert_start === 1'b1) n_conv <= n_conv + 1;
  end

  asr_readout asr_readout_i (
    .mclk                 (mclk),
    .reset                (reset),
    .chip_select_n        (chip_select_n),
    .read_convert         (read_convert),
    .ext_clock_select     (ext_clock_select),
    .output_format_select (output_format_select),
    .chain_in             (chain_in),
    .result_word          (result_word),
    .result_load          (result_load),
    .serial_bit_clock_in  (bit_clock_pin),
    .serial_bit_clock_o   (sbc_o),
    .serial_bit_clock_oe  (sbc_oe),
    .serial_data          (serial_data),
    .word_start_pulse     (word_start_pulse),
    .convert_start        (convert_start),
    .read_active          (read_active)
  );

  asr_host_model asr_host_model_i (
    .bclk  (host_clk),
    .sdata (serial_data),
    .wsp   (word_start_pulse)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // format is synced, so it settles before the capture pulse
  task automatic load(input logic [15:0] v, input logic fmt);
    @(posedge mclk);
    output_format_select <= fmt;
    tick(3);
    result_word <= v;
    result_load <= 1'b1;
    @(posedge mclk);
    result_load <= 1'b0;
  endtask : load

  task automatic wait_read(input logic lvl);
    int i;
    i = 0;
    while (read_active !== lvl && i < 20) begin
      @(posedge mclk);
      #1;
      i++;
    end
    check(16'(read_active), 16'(lvl));
  endtask : wait_read

  // read/convert already low: select falls second and starts it
  task automatic int_frame(input logic [15:0] exp, input logic t);
    logic       prev;
    logic       b;
    int         n;
    int         c0;
    w = 16'h0000;
    prev = 1'b0;
    b = 1'b0;
    n = 0;
    c0 = n_conv;
    @(posedge mclk);
    chain_in <= t;
    tick(3);
    chip_select_n <= 1'b0;
    repeat (70) begin
      @(posedge mclk);
      #1;
      if (sbc_o === 1'b1 && prev === 1'b0) begin
        w = {w[14:0], serial_data};
        b = serial_data;
        n++;
      end
      if (sbc_o === 1'b0 && prev === 1'b1) check(16'(serial_data), 16'(b));
      prev = sbc_o;
    end
    check(16'(n), 16'd16);
    check(w, exp);
    check(16'(serial_data), 16'(t));
    check(16'(sbc_o), 16'h0000);
    check(16'(sbc_oe), 16'h0001);
    check(16'(n_conv - c0), 16'h0001);
    @(posedge mclk);
    chip_select_n <= 1'b1;
  endtask : int_frame

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    tick(3);
    reset <= 1'b0;
    read_convert <= 1'b0;
    load(16'hc3a5, 1'b1);
    int_frame(16'hc3a5, 1'b0);
    load(16'h5a96, 1'b0);
    int_frame(16'hda96, 1'b1);
    @(posedge mclk);
    ext_clock_select <= 1'b1;
    read_convert <= 1'b1;
    chain_in <= 1'b1;
    tick(4);
    #1;
    check(16'(sbc_oe), 16'h0000);
    #7;
    asr_host_model_i.clocks(6);
    @(posedge mclk);
    chip_select_n <= 1'b0;
    wait_read(1'b1);
    asr_host_model_i.read_word(1'b1, w, tag, ws, unstable);
    check(16'(ws), 16'h0001);
    check(w, 16'hda96);
    check(16'(tag), 16'h0001);
    check(16'(unstable), 16'h0000);
    @(posedge mclk);
    chip_select_n <= 1'b1;
    wait_read(1'b0);
    load(16'h0001, 1'b1);
    read_convert <= 1'b0;
    chain_in <= 1'b0;
    tick(3);
    chip_select_n <= 1'b0;
    tick(6);
    read_convert <= 1'b1;
    wait_read(1'b1);
    asr_host_model_i.read_word(1'b0, w, tag, ws, unstable);
    check(16'(ws), 16'h0000);
    check(w, 16'h0001);
    check(16'(tag), 16'h0000);
    check(16'(unstable), 16'h0000);
    @(posedge mclk);
    read_convert <= 1'b0;
    wait_read(1'b0);
    tick(4);
    chip_select_n <= 1'b1;
    check(16'(n_conv), 16'h0004);
    conclude();
  end

  // whole run is a few hundred cycles; this is ten thousand
  initial begin
    #1_000_000;
    fails++;
    conclude();
  end
endmodule : asr_readout_test
